// >>> include/dca_params.svh
// Constants for the DDR3L command, address and rank-control port
// Function
// - Read or Write drives A10 high for auto-precharge, low to keep bank open.
// - Precharge drives A10 low for one bank, high for all banks.
// - Single-bank Precharge names its bank on the three bank select outputs.
// - Read or Write drives A12 high for full burst, low for chop.
// - Row and column addresses share one 16-bit bus, multiplexed by command.
// - Bank select outputs choose the bank inside the addressed rank.
// - One active-low select per rank; only the addressed rank is selected, except that self-refresh entry selects all ranks.
// - One clock enable per rank for power-up init and power-down.
// - Suspend moves all ranks into self-refresh; resume brings them out.
// - One termination control output per rank switches its termination.
// - Commands are encoded on active-low row, column and write strobes.
`ifndef DCA_PARAMS_SVH
`define DCA_PARAMS_SVH
`define DCA_ADDR_W      16
`define DCA_BANK_W      3
`define DCA_RANKS       4
`define DCA_AP_BIT      10
`define DCA_BC_BIT      12
`define DCA_SEL_IDLE    4'hF
`define DCA_RANKS_BASE  4'h3
`define DCA_RANKS_WIDE  4'hF
`define DCA_CNT_W       16
`define DCA_CLK_NS      10
`define DCA_POWERUP_NS  500000
`define DCA_POWERUP_CYC ((`DCA_POWERUP_NS + `DCA_CLK_NS - 1) / `DCA_CLK_NS)
`define DCA_SR_EXIT_NS  200
`define DCA_SR_EXIT_CYC ((`DCA_SR_EXIT_NS + `DCA_CLK_NS - 1) / `DCA_CLK_NS)
`endif

// >>> include/dca_pkg.sv
// Types shared by the command port and its per-channel encoder
package dca_pkg;
    typedef enum logic [3:0] {
        DCA_CMD_NOP = 4'h0,
        DCA_CMD_ACT = 4'h1,
        DCA_CMD_RD  = 4'h2,
        DCA_CMD_WR  = 4'h3,
        DCA_CMD_PRE = 4'h4,
        DCA_CMD_REF = 4'h5,
        DCA_CMD_SRE = 4'h6,
        DCA_CMD_MRS = 4'h7,
        DCA_CMD_ZQ  = 4'h8
    } dca_cmd_type;

    typedef enum logic [3:0] {
        DCA_ST_INIT     = 4'h1,
        DCA_ST_RUN      = 4'h2,
        DCA_ST_SELF_REF = 4'h4,
        DCA_ST_SR_EXIT  = 4'h8
    } dca_state_type;
endpackage

// >>> logic/dca_chan_port.sv
// One channel's command encoder with registered command and rank outputs
`timescale 1ns/1ns
`include "dca_params.svh"
module dca_chan_port
    import dca_pkg::*;
(
    input  wire logic                   clk_in,
    input  wire logic                   rst_n_in,
    input  wire logic                   slot_in,
    input  wire logic                   take_in,
    input  wire dca_cmd_type            cmd_in,
    input  wire logic [`DCA_RANKS-1:0]  rank_mask_in,
    input  wire logic [`DCA_BANK_W-1:0] bank_in,
    input  wire logic [`DCA_ADDR_W-1:0] addr_in,
    input  wire logic                   auto_pre_in,
    input  wire logic                   chop_in,
    input  wire logic                   all_banks_in,
    input  wire logic [`DCA_RANKS-1:0]  cke_want_in,
    input  wire logic [`DCA_RANKS-1:0]  odt_want_in,
    output logic      [`DCA_ADDR_W-1:0] mem_addr_out,
    output logic      [`DCA_BANK_W-1:0] bank_sel_out,
    output logic      [`DCA_RANKS-1:0]  select_n_out,
    output logic                        row_strobe_n_out,
    output logic                        col_strobe_n_out,
    output logic                        write_cmd_n_out,
    output logic      [`DCA_RANKS-1:0]  clock_enable_out,
    output logic      [`DCA_RANKS-1:0]  termination_out
);
    dca_cmd_type            eff_cmd;
    logic                   is_rw;
    logic [2:0]             next_code;
    logic [`DCA_ADDR_W-1:0] col_addr;
    logic [`DCA_ADDR_W-1:0] pre_addr;
    logic [`DCA_ADDR_W-1:0] next_addr;

    // Idle slots fall back to a deselect so stale commands never repeat
    assign eff_cmd = take_in ? cmd_in : DCA_CMD_NOP;
    assign is_rw   = (eff_cmd == DCA_CMD_RD) || (eff_cmd == DCA_CMD_WR);
    assign next_code = (eff_cmd == DCA_CMD_ACT) ? 3'h3 :
                       (eff_cmd == DCA_CMD_RD)  ? 3'h5 :
                       (eff_cmd == DCA_CMD_WR)  ? 3'h4 :
                       (eff_cmd == DCA_CMD_PRE) ? 3'h2 :
                       (eff_cmd == DCA_CMD_REF) ? 3'h1 :
                       (eff_cmd == DCA_CMD_SRE) ? 3'h1 :
                       (eff_cmd == DCA_CMD_MRS) ? 3'h0 :
                       (eff_cmd == DCA_CMD_ZQ)  ? 3'h6 : 3'h7;
    // column form carries auto-precharge and chop
    assign col_addr = {addr_in[15:13], ~chop_in, addr_in[11], auto_pre_in, addr_in[9:0]};
    assign pre_addr = {5'h00, all_banks_in, 10'h000};
    // one bus, row or column by command
    assign next_addr = is_rw ? col_addr :
                       (eff_cmd == DCA_CMD_PRE) ? pre_addr : addr_in;

    // Update only on the memory clock's falling slot; hold for a full period
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mem_addr_out     <= 16'h0000;
            bank_sel_out     <= 3'h0;
            select_n_out     <= `DCA_SEL_IDLE;
            {row_strobe_n_out, col_strobe_n_out, write_cmd_n_out} <= 3'h7;
            clock_enable_out <= 4'h0;
            termination_out  <= 4'h0;
        end else if (slot_in) begin
            mem_addr_out     <= next_addr;
            bank_sel_out     <= bank_in;
            select_n_out     <= take_in ? ~rank_mask_in : `DCA_SEL_IDLE;
            {row_strobe_n_out, col_strobe_n_out, write_cmd_n_out} <= next_code;
            clock_enable_out <= cke_want_in;
            termination_out  <= odt_want_in;
        end
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    rw_autopre_a: assert property (
        slot_in && take_in && (cmd_in == DCA_CMD_RD || cmd_in == DCA_CMD_WR) |=>
        mem_addr_out[`DCA_AP_BIT] == $past(auto_pre_in) ##1
        mem_addr_out[`DCA_AP_BIT] == $past(auto_pre_in, 2))
        else $error("auto-precharge bit wrong on read or write");
    pre_scope_a: assert property (
        slot_in && take_in && cmd_in == DCA_CMD_PRE |=>
        mem_addr_out[`DCA_AP_BIT] == $past(all_banks_in) && !row_strobe_n_out
        && col_strobe_n_out && !write_cmd_n_out)
        else $error("precharge scope or code wrong");
    pre_bank_a: assert property (
        slot_in && take_in && cmd_in == DCA_CMD_PRE && !all_banks_in |=>
        bank_sel_out == $past(bank_in))
        else $error("precharge bank not presented");
    chop_bit_a: assert property (
        slot_in && take_in && (cmd_in == DCA_CMD_RD || cmd_in == DCA_CMD_WR) |=>
        mem_addr_out[`DCA_BC_BIT] == !$past(chop_in))
        else $error("burst chop bit wrong");
    row_addr_a: assert property (
        slot_in && take_in && cmd_in == DCA_CMD_ACT |=>
        mem_addr_out == $past(addr_in) && !row_strobe_n_out && col_strobe_n_out)
        else $error("activate row address wrong");
    idle_desel_a: assert property (
        slot_in && !take_in |=> select_n_out == `DCA_SEL_IDLE [*2])
        else $error("rank selected with no command");
    write_code_a: assert property (
        slot_in && take_in && cmd_in == DCA_CMD_WR |=>
        {row_strobe_n_out, col_strobe_n_out, write_cmd_n_out} == 3'h4)
        else $error("write strobe code wrong");
    hold_slot_a: assert property (
        !slot_in |=> $stable(mem_addr_out) && $stable(select_n_out))
        else $error("command changed outside its slot");
    read_ap_c: cover property (slot_in && take_in && cmd_in == DCA_CMD_RD && auto_pre_in);
    pre_all_c: cover property (slot_in && take_in && cmd_in == DCA_CMD_PRE && all_banks_in);
endmodule // dca_chan_port

// >>> logic/dca_cmd_addr_port.sv
// Two-channel DDR3L command, address and rank-control port
`timescale 1ns/1ns
`include "dca_params.svh"
module dca_cmd_addr_port
    import dca_pkg::*;
#(
    parameter logic                  WIDE_CONFIG    = 1'b1,
    parameter logic [`DCA_CNT_W-1:0] POWERUP_CYCLES = `DCA_CNT_W'(`DCA_POWERUP_CYC)
)(
    input  wire logic                   core_clk_in,
    input  wire logic                   arst_n_in,
    input  wire logic                   suspend_to_ram_in,
    input  wire logic                   ch0_valid_in,
    input  wire dca_cmd_type            ch0_cmd_in,
    input  wire logic [1:0]             ch0_rank_in,
    input  wire logic [`DCA_BANK_W-1:0] ch0_bank_in,
    input  wire logic [`DCA_ADDR_W-1:0] ch0_addr_in,
    input  wire logic                   ch0_auto_pre_in,
    input  wire logic                   ch0_chop_in,
    input  wire logic                   ch0_all_banks_in,
    input  wire logic [`DCA_RANKS-1:0]  ch0_odt_in,
    input  wire logic [`DCA_RANKS-1:0]  ch0_power_down_in,
    input  wire logic                   ch1_valid_in,
    input  wire dca_cmd_type            ch1_cmd_in,
    input  wire logic [1:0]             ch1_rank_in,
    input  wire logic [`DCA_BANK_W-1:0] ch1_bank_in,
    input  wire logic [`DCA_ADDR_W-1:0] ch1_addr_in,
    input  wire logic                   ch1_auto_pre_in,
    input  wire logic                   ch1_chop_in,
    input  wire logic                   ch1_all_banks_in,
    input  wire logic [`DCA_RANKS-1:0]  ch1_odt_in,
    input  wire logic [`DCA_RANKS-1:0]  ch1_power_down_in,
    output logic                        cmd_ready_out,
    output logic                        self_refresh_out,
    output logic      [`DCA_RANKS-1:0]  ch0_mem_clk_p_out,
    output logic      [`DCA_RANKS-1:0]  ch0_mem_clk_n_out,
    output logic      [`DCA_RANKS-1:0]  ch1_mem_clk_p_out,
    output logic      [`DCA_RANKS-1:0]  ch1_mem_clk_n_out,
    output logic      [`DCA_ADDR_W-1:0] ch0_mem_addr_out,
    output logic      [`DCA_BANK_W-1:0] ch0_bank_sel_out,
    output logic      [`DCA_RANKS-1:0]  ch0_rank_select_n_out,
    output logic                        ch0_row_strobe_n_out,
    output logic                        ch0_col_strobe_n_out,
    output logic                        ch0_write_cmd_n_out,
    output logic      [`DCA_RANKS-1:0]  ch0_rank_clock_enable_out,
    output logic      [`DCA_RANKS-1:0]  ch0_rank_termination_ctl_out,
    output logic      [`DCA_ADDR_W-1:0] ch1_mem_addr_out,
    output logic      [`DCA_BANK_W-1:0] ch1_bank_sel_out,
    output logic      [`DCA_RANKS-1:0]  ch1_rank_select_n_out,
    output logic                        ch1_row_strobe_n_out,
    output logic                        ch1_col_strobe_n_out,
    output logic                        ch1_write_cmd_n_out,
    output logic      [`DCA_RANKS-1:0]  ch1_rank_clock_enable_out,
    output logic      [`DCA_RANKS-1:0]  ch1_rank_termination_ctl_out
);
    // upper ranks only in the wide configuration
    localparam logic [`DCA_RANKS-1:0] EXIST = WIDE_CONFIG ? `DCA_RANKS_WIDE : `DCA_RANKS_BASE;

    logic                  rst_meta;
    logic                  rst_n;
    logic                  str_meta;
    logic                  str_sync;
    logic                  ph;
    logic [`DCA_RANKS-1:0] mclk_p;
    logic [`DCA_RANKS-1:0] mclk_n;
    logic [`DCA_CNT_W-1:0] cnt;
    dca_state_type         state;
    dca_state_type         next_state;
    logic                  slot;
    logic                  cnt_done;
    logic [`DCA_CNT_W-1:0] cnt_limit;
    logic                  sre_issue;
    logic                  sr_leave;
    logic                  next_ready;
    logic                  ch0_take;
    logic                  ch1_take;
    logic [`DCA_RANKS-1:0] ch0_user_mask;
    logic [`DCA_RANKS-1:0] ch1_user_mask;
    logic [`DCA_RANKS-1:0] ch0_cke_want;
    logic [`DCA_RANKS-1:0] ch1_cke_want;
    logic [`DCA_RANKS-1:0] base_cke;
    dca_cmd_type           ch0_cmd;
    dca_cmd_type           ch1_cmd;

    // Reset released through two flops; assert stays asynchronous
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Suspend request is a pin level; synchronise before any use
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            str_meta <= 1'b0;
            str_sync <= 1'b0;
        end else begin
            str_meta <= suspend_to_ram_in;
            str_sync <= str_meta;
        end
    end

    // forwarded clock pair per rank, half the core rate
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ph     <= 1'b0;
            mclk_p <= 4'h0;
            mclk_n <= 4'h0;
        end else begin
            ph     <= ~ph;
            mclk_p <= ph ? 4'h0 : EXIST;
            mclk_n <= ph ? EXIST : 4'h0;
        end
    end
    assign ch0_mem_clk_p_out = mclk_p;
    assign ch0_mem_clk_n_out = mclk_n;
    assign ch1_mem_clk_p_out = mclk_p;
    assign ch1_mem_clk_n_out = mclk_n;

    // slot sits on the falling clock; data strobes are a separate path
    assign slot = ph;

    // Wait counter shared by power-up hold and self-refresh exit
    assign cnt_limit = (state == DCA_ST_INIT) ? POWERUP_CYCLES : `DCA_CNT_W'(`DCA_SR_EXIT_CYC);
    assign cnt_done  = cnt >= cnt_limit;
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 16'h0000;
        end else if (state != next_state) begin
            cnt <= 16'h0000;
        end else if (!cnt_done) begin
            cnt <= cnt + 16'h0001;
        end
    end

    // self-refresh entry waits for a slot the host could not use
    assign sre_issue = (state == DCA_ST_RUN) && str_sync && slot && !cmd_ready_out;
    assign sr_leave  = (state == DCA_ST_SELF_REF) && !str_sync && slot;

    // Power sequencing state
    always_comb begin
        next_state = state;
        case (state)
            DCA_ST_INIT:     if (cnt_done && slot) next_state = DCA_ST_RUN;
            DCA_ST_RUN:      if (sre_issue) next_state = DCA_ST_SELF_REF;
            DCA_ST_SELF_REF: if (sr_leave) next_state = DCA_ST_SR_EXIT;
            DCA_ST_SR_EXIT:  if (cnt_done) next_state = DCA_ST_RUN;
            default:         next_state = DCA_ST_INIT;
        endcase
    end

    // Ready only ahead of a slot, so a taken command meets its slot
    assign next_ready = !ph && (next_state == DCA_ST_RUN) && !str_sync;
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state            <= DCA_ST_INIT;
            cmd_ready_out    <= 1'b0;
            self_refresh_out <= 1'b0;
        end else begin
            state            <= next_state;
            cmd_ready_out    <= next_ready;
            self_refresh_out <= next_state == DCA_ST_SELF_REF;
        end
    end

    // clock enables: low through power-up, then per-rank power-down
    assign base_cke = ((state == DCA_ST_INIT) && cnt_done) || sr_leave
                      || (state == DCA_ST_SR_EXIT) ? EXIST : 4'h0;
    assign ch0_cke_want = (state == DCA_ST_RUN && !sre_issue) ? EXIST & ~ch0_power_down_in
                                                              : base_cke;
    assign ch1_cke_want = (state == DCA_ST_RUN && !sre_issue) ? EXIST & ~ch1_power_down_in
                                                              : base_cke;

    // each channel decoded on its own; entry hits all ranks
    assign ch0_take      = (ch0_valid_in && cmd_ready_out) || sre_issue;
    assign ch1_take      = (ch1_valid_in && cmd_ready_out) || sre_issue;
    assign ch0_user_mask = sre_issue ? EXIST : EXIST & (4'h1 << ch0_rank_in);
    assign ch1_user_mask = sre_issue ? EXIST : EXIST & (4'h1 << ch1_rank_in);
    assign ch0_cmd       = sre_issue ? DCA_CMD_SRE : ch0_cmd_in;
    assign ch1_cmd       = sre_issue ? DCA_CMD_SRE : ch1_cmd_in;

    dca_chan_port u_ch0 (
        .clk_in           (core_clk_in),
        .rst_n_in         (rst_n),
        .slot_in          (slot),
        .take_in          (ch0_take),
        .cmd_in           (ch0_cmd),
        .rank_mask_in     (ch0_user_mask),
        .bank_in          (ch0_bank_in),
        .addr_in          (ch0_addr_in),
        .auto_pre_in      (ch0_auto_pre_in),
        .chop_in          (ch0_chop_in),
        .all_banks_in     (ch0_all_banks_in),
        .cke_want_in      (ch0_cke_want),
        .odt_want_in      ((state == DCA_ST_RUN) ? EXIST & ch0_odt_in : 4'h0),
        .mem_addr_out     (ch0_mem_addr_out),
        .bank_sel_out     (ch0_bank_sel_out),
        .select_n_out     (ch0_rank_select_n_out),
        .row_strobe_n_out (ch0_row_strobe_n_out),
        .col_strobe_n_out (ch0_col_strobe_n_out),
        .write_cmd_n_out  (ch0_write_cmd_n_out),
        .clock_enable_out (ch0_rank_clock_enable_out),
        .termination_out  (ch0_rank_termination_ctl_out)
    );

    dca_chan_port u_ch1 (
        .clk_in           (core_clk_in),
        .rst_n_in         (rst_n),
        .slot_in          (slot),
        .take_in          (ch1_take),
        .cmd_in           (ch1_cmd),
        .rank_mask_in     (ch1_user_mask),
        .bank_in          (ch1_bank_in),
        .addr_in          (ch1_addr_in),
        .auto_pre_in      (ch1_auto_pre_in),
        .chop_in          (ch1_chop_in),
        .all_banks_in     (ch1_all_banks_in),
        .cke_want_in      (ch1_cke_want),
        .odt_want_in      ((state == DCA_ST_RUN) ? EXIST & ch1_odt_in : 4'h0),
        .mem_addr_out     (ch1_mem_addr_out),
        .bank_sel_out     (ch1_bank_sel_out),
        .select_n_out     (ch1_rank_select_n_out),
        .row_strobe_n_out (ch1_row_strobe_n_out),
        .col_strobe_n_out (ch1_col_strobe_n_out),
        .write_cmd_n_out  (ch1_write_cmd_n_out),
        .clock_enable_out (ch1_rank_clock_enable_out),
        .termination_out  (ch1_rank_termination_ctl_out)
    );

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n);

    init_cke_a: assert property (
        state == DCA_ST_INIT && !(cnt_done && slot) |=>
        ch0_rank_clock_enable_out == 4'h0 && ch1_rank_clock_enable_out == 4'h0)
        else $error("clock enable high before power-up hold ends");
    sr_cke_a: assert property (
        state == DCA_ST_SELF_REF && str_sync |->
        ch0_rank_clock_enable_out == 4'h0 && ch1_rank_clock_enable_out == 4'h0)
        else $error("rank awake during self-refresh");
    sr_entry_a: assert property (
        state == DCA_ST_RUN && $rose(str_sync) |-> ##[1:4] state == DCA_ST_SELF_REF)
        else $error("self-refresh entry late");
    sr_resume_a: assert property (
        state == DCA_ST_SELF_REF && !str_sync |-> ##[1:30] state == DCA_ST_RUN)
        else $error("self-refresh exit late");
    rank_exist_a: assert property (
        !WIDE_CONFIG |-> ch0_rank_select_n_out[3:2] == 2'h3
        && ch1_rank_clock_enable_out[3:2] == 2'h0)
        else $error("absent rank driven");
    clk_pair_a: assert property (
        mclk_p[0] |=> !mclk_p[0] && mclk_n[0] ##1 mclk_p[0] && !mclk_n[0])
        else $error("forwarded clock pair broken");
    chan_indep_a: assert property (
        slot && ch0_take && !ch1_take |=> ch1_rank_select_n_out == `DCA_SEL_IDLE)
        else $error("channel one selected by channel zero command");
    self_ref_c: cover property (state == DCA_ST_SELF_REF ##[1:100] state == DCA_ST_RUN);
    chop_c: cover property (ch0_take && ch0_cmd_in == DCA_CMD_WR && ch0_chop_in);
endmodule // dca_cmd_addr_port

// >>> verification/dca_sdram_model.sv
// Behavioural SDRAM rank group latching commands at the forwarded clock rise
`timescale 1ns/1ns
module dca_sdram_model (
    input  wire logic       mem_clk_p_in,
    input  wire logic [3:0] select_n_in,
    input  wire logic [2:0] strobes_in,
    output logic      [2:0] last_cmd_out
);
    // Idle value until the first selected command arrives; one driver only
    logic [2:0] last_cmd = 3'h7;

    always @(posedge mem_clk_p_in) begin
        // Deselected slots carry no command, so they are ignored
        if (select_n_in != 4'hF) begin
            last_cmd <= strobes_in;
        end
    end
    assign last_cmd_out = last_cmd;
endmodule // dca_sdram_model

// >>> verification/dca_cmd_addr_port_tb.sv
// Self-checking bench for the two-channel command, address and rank port
`timescale 1ns/1ns
`include "dca_params.svh"
module dca_cmd_addr_port_tb;
    import dca_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, susp = 1'b0, rdy, sref;
    logic        v[2], ap[2], chop[2], allb[2], ras_o[2], cas_o[2], we_o[2];
    dca_cmd_type cmd[2];
    logic [1:0]  rank[2];
    logic [2:0]  bank[2], bank_o[2], m_cmd[2];
    logic [15:0] addr[2], addr_o[2];
    logic [3:0]  odt[2], pd[2], sel_o[2], cke_o[2], odt_o[2], ckp[2], ckn[2];
    int          fails = 0, n_checks = 0, cyc = 0;
    // Strobe levels {ras, cas, we} indexed by command code
    logic [2:0]  strb_lut[9] = '{3'h7, 3'h3, 3'h5, 3'h4, 3'h2, 3'h1, 3'h1, 3'h0, 3'h6};

    // Short power-up count keeps the run brief
    dca_cmd_addr_port #(.WIDE_CONFIG(1'b1), .POWERUP_CYCLES(16'h0014)) dut (
        .core_clk_in(clk), .arst_n_in(rst_n), .suspend_to_ram_in(susp),
        .ch0_valid_in(v[0]), .ch0_cmd_in(cmd[0]), .ch0_rank_in(rank[0]),
        .ch0_bank_in(bank[0]), .ch0_addr_in(addr[0]), .ch0_auto_pre_in(ap[0]),
        .ch0_chop_in(chop[0]), .ch0_all_banks_in(allb[0]), .ch0_odt_in(odt[0]),
        .ch0_power_down_in(pd[0]), .ch1_valid_in(v[1]), .ch1_cmd_in(cmd[1]),
        .ch1_rank_in(rank[1]), .ch1_bank_in(bank[1]), .ch1_addr_in(addr[1]),
        .ch1_auto_pre_in(ap[1]), .ch1_chop_in(chop[1]), .ch1_all_banks_in(allb[1]),
        .ch1_odt_in(odt[1]), .ch1_power_down_in(pd[1]), .cmd_ready_out(rdy),
        .self_refresh_out(sref), .ch0_mem_clk_p_out(ckp[0]), .ch0_mem_clk_n_out(ckn[0]),
        .ch1_mem_clk_p_out(ckp[1]), .ch1_mem_clk_n_out(ckn[1]),
        .ch0_mem_addr_out(addr_o[0]), .ch0_bank_sel_out(bank_o[0]),
        .ch0_rank_select_n_out(sel_o[0]), .ch0_row_strobe_n_out(ras_o[0]),
        .ch0_col_strobe_n_out(cas_o[0]), .ch0_write_cmd_n_out(we_o[0]),
        .ch0_rank_clock_enable_out(cke_o[0]), .ch0_rank_termination_ctl_out(odt_o[0]),
        .ch1_mem_addr_out(addr_o[1]), .ch1_bank_sel_out(bank_o[1]),
        .ch1_rank_select_n_out(sel_o[1]), .ch1_row_strobe_n_out(ras_o[1]),
        .ch1_col_strobe_n_out(cas_o[1]), .ch1_write_cmd_n_out(we_o[1]),
        .ch1_rank_clock_enable_out(cke_o[1]), .ch1_rank_termination_ctl_out(odt_o[1]));

    // One far-side model per channel
    dca_sdram_model mdl0 (.mem_clk_p_in(ckp[0][0]), .select_n_in(sel_o[0]),
        .strobes_in({ras_o[0], cas_o[0], we_o[0]}), .last_cmd_out(m_cmd[0]));
    dca_sdram_model mdl1 (.mem_clk_p_in(ckp[1][0]), .select_n_in(sel_o[1]),
        .strobes_in({ras_o[1], cas_o[1], we_o[1]}), .last_cmd_out(m_cmd[1]));

    always #5 clk = ~clk;

    task automatic close_out;
        if (fails == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Hang guard well above the expected run of under 200 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            fails++;
            close_out;
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Bounded wait for a slot where a request is taken
    task automatic wait_ready;
        int i;
        i = 0;
        @(negedge clk);
        while (rdy !== 1'b1 && i < 400) begin
            @(negedge clk);
            i++;
        end
        // A ready that never comes is a failure in its own right
        if (rdy !== 1'b1) begin
            fails++;
            $display("[FAIL] %0t ready never rose", $time);
        end
    endtask

    task automatic issue(input dca_cmd_type c, input logic [1:0] r, input logic [2:0] b,
                         input logic [15:0] a, input logic p, input logic h, input logic l);
        logic [15:0] ea;
        ea = (c == DCA_CMD_RD || c == DCA_CMD_WR) ? {a[15:13], ~h, a[11], p, a[9:0]} :
             (c == DCA_CMD_PRE) ? {5'h00, l, 10'h000} : a;
        wait_ready;
        for (int n = 0; n < 2; n++) begin
            v[n] = 1'b1; cmd[n] = c; rank[n] = r ^ 2'(n); bank[n] = b; addr[n] = a;
            ap[n] = p; chop[n] = h; allb[n] = l;
        end
        @(negedge clk);
        v[0] = 1'b0; v[1] = 1'b0;
        for (int n = 0; n < 2; n++) begin
            chk(addr_o[n], ea);
            chk(16'(bank_o[n]), 16'(b));
            chk(16'(sel_o[n]), 16'(4'(~(4'h1 << (r ^ 2'(n))))));
            chk(16'({ras_o[n], cas_o[n], we_o[n]}), 16'(strb_lut[c]));
        end
        @(negedge clk);
        chk(16'(m_cmd[0]), 16'(strb_lut[c]));
    endtask

    task automatic powerup;
        repeat (5) @(negedge clk);
        chk(16'(cke_o[0]), 16'h0000);
        wait_ready;
        chk(16'({cke_o[1], cke_o[0]}), 16'h00FF);
        chk(16'({ckp[1] ^ ckn[1], ckp[0] ^ ckn[0]}), 16'h00FF);
    endtask

    // Every command except self-refresh, flag bits flipped on the second pass
    task automatic cmd_table;
        for (int j = 0; j < 2; j++)
            for (int k = 0; k < 9; k++)
                if (k != 6) issue(dca_cmd_type'(k), 2'(k), 3'(k ^ j), 16'hA5C3 ^ 16'(k),
                                  1'(k ^ j), 1'((k >> 1) ^ j), 1'(j));
    endtask

    task automatic pd_odt;
        pd[0] = 4'h5; odt[0] = 4'h3; odt[1] = 4'h8;
        repeat (4) @(negedge clk);
        chk(16'({cke_o[1], cke_o[0]}), 16'h00FA);
        chk(16'({odt_o[1], odt_o[0]}), 16'h0083);
        pd[0] = 4'h0;
    endtask

    // Lone channel zero request must leave channel one deselected
    task automatic one_chan;
        wait_ready;
        v[0] = 1'b1;
        @(negedge clk);
        v[0] = 1'b0;
        chk(16'({sel_o[1], sel_o[0]}), 16'h00FE);
    endtask

    task automatic suspend;
        int i;
        i = 0;
        susp = 1'b1;
        while (sref !== 1'b1 && i < 20) begin
            @(negedge clk);
            i++;
        end
        if (sref !== 1'b1) begin
            fails++;
            $display("[FAIL] %0t self-refresh never entered", $time);
        end
        // Entry slot still belongs to run; termination drops at the next slot
        repeat (2) @(negedge clk);
        chk(16'({cke_o[1], cke_o[0], odt_o[0]}), 16'h0000);
        chk(16'({m_cmd[1], m_cmd[0]}), 16'h0009);
        susp = 1'b0;
        wait_ready;
        chk(16'({cke_o[1], cke_o[0]}), 16'h00FF);
    endtask

    initial begin
        for (int n = 0; n < 2; n++) begin
            v[n] = 1'b0; cmd[n] = DCA_CMD_NOP; rank[n] = 2'h0; bank[n] = 3'h0;
            addr[n] = 16'h0000; ap[n] = 1'b0; chop[n] = 1'b0; allb[n] = 1'b0;
            odt[n] = 4'h0; pd[n] = 4'h0;
        end
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        powerup;
        cmd_table;
        pd_odt;
        one_chan;
        suspend;
        close_out;
    end
endmodule // dca_cmd_addr_port_tb
